/* File: shared/spw_regs.svh */
// Purpose: Constants of the serial card power switch control block
// Assumes: 20 MHz ref_clk_i, AXI4-Lite register access
// Notes: Offsets are byte addresses
`ifndef SPW_REGS_SVH
`define SPW_REGS_SVH
`define SPW_WORD_W 9
`define SPW_PDOWN_POS 8
`define SPW_A_PROG_LSB 0
`define SPW_A_SUP_LSB 2
`define SPW_B_PROG_LSB 4
`define SPW_B_SUP_LSB 6
`define SPW_OFF_CTRL 4'h0
`define SPW_OFF_STATUS 4'h4
`define SPW_OFF_IRQ 4'h8
`define SPW_OFF_MASK 4'hC
`define SPW_CTRL_RST 2'h0
`define SPW_MASK_RST 4'h0
`define SPW_IRQ_LATCH 0
`define SPW_IRQ_OVER 1
`define SPW_IRQ_THERM 2
`define SPW_IRQ_LOCK 3
`endif

/* File: shared/spw_pkg.sv */
// Purpose: Types of the serial card power switch control block
// Assumes: Constants live in spw_regs.svh
// Notes: Rail states are one-hot switch selects
package spw_pkg;
   typedef enum logic [1:0] {SPW_SUP_GND, SPW_SUP_LOW, SPW_SUP_HIGH, SPW_SUP_OFF} spw_sup_t;
   typedef enum logic [1:0] {SPW_PRG_GND, SPW_PRG_VCC, SPW_PRG_HIGH, SPW_PRG_OFF} spw_prg_t;
   typedef struct packed {
      logic gnd;
      logic low_rail_sel;
      logic high_rail_sel;
   } spw_sup_sw_t;
   typedef struct packed {
      logic gnd;
      logic vcc_sel;
      logic prog_high_sel;
   } spw_prg_sw_t;
   typedef struct packed {
      spw_sup_sw_t supply;
      spw_prg_sw_t prog;
   } spw_slot_sw_t;
endpackage : spw_pkg

/* File: design/spw_sync.sv */
// Purpose: Two flip-flop synchroniser for pin levels
// Assumes: Inputs are asynchronous to ref_clk_i
// Notes: First stage is read only by the second
`timescale 1ns/10ps
module spw_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta_q;

   if (W < 1)
   begin : g_bad_width
      $error("spw_sync needs a width of at least one bit");
   end

   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         meta_q <= '0;
         sync_o <= '0;
      end
      else
      begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule : spw_sync

/* File: design/spw_slot_decode.sv */
// Purpose: Decode one slot's four control bits into switch selects
// Assumes: Caller applies fault and shutdown overrides via enable_i
// Notes: Purely combinational
`timescale 1ns/10ps
module spw_slot_decode
   import spw_pkg::*;
(
   input wire logic enable_i,
   input wire logic [1:0] sup_code_i,
   input wire logic [1:0] prg_code_i,
   output spw_slot_sw_t sw_o
);
   always_comb
   begin
      sw_o = '0;
      if (enable_i)
      begin
         case (spw_sup_t'(sup_code_i))
            SPW_SUP_LOW: sw_o.supply.low_rail_sel = 1'b1;
            SPW_SUP_HIGH: sw_o.supply.high_rail_sel = 1'b1;
            default: sw_o.supply.gnd = 1'b1; // Both 00 and 11 discharge
         endcase
         case (spw_prg_t'(prg_code_i))
            SPW_PRG_GND: sw_o.prog.gnd = 1'b1;
            SPW_PRG_VCC: sw_o.prog.vcc_sel = 1'b1;
            SPW_PRG_HIGH: sw_o.prog.prog_high_sel = 1'b1;
            default: sw_o.prog = '0;
         endcase
      end
   end
endmodule : spw_slot_decode

/* File: design/spw_ctrl.sv */
// Purpose: Serial control word capture, rail decode and fault handling
// Assumes: Link pins are asynchronous, sampled by ref_clk_i through two flops
// Notes: Link clock must stay well below ref_clk_i / 4 to be seen
//
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/10ps
`include "spw_regs.svh"

module spw_ctrl
   import spw_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic resetn_i,
   input wire logic ser_data_i,
   input wire logic ser_clk_i,
   input wire logic ser_latch_i,
   input wire logic [3:0] over_cur_i,
   input wire logic therm_hot_i,
   input wire logic [3:0] below_gnd_i,
   output spw_slot_sw_t slot_a_sw_o,
   output spw_slot_sw_t slot_b_sw_o,
   output logic [3:0] limit_en_o,
   output logic quiescent_o,
   output logic fault_current_flag_n_o,
   output logic irq_o,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   localparam int NPIN = 8;
   logic [NPIN-1:0] pin_s;
   logic data_s, clk_s, latch_s, hot_s;
   logic [3:0] over_cur_s, bgnd_s;
   logic clk_prev_q, latch_prev_q;
   logic clk_rise, latch_rise;
   logic [`SPW_WORD_W-1:0] shift_q;
   logic [`SPW_WORD_W-1:0] word_q;
   logic lock_q;
   logic [1:0] ctrl_q;
   logic [3:0] irq_q, mask_q, irq_set;
   logic over_any_prev_q, hot_prev_q;
   logic rail_en;

   // Fault inputs come from analog comparators, so they are pins too
   spw_sync #(.W(NPIN)) u_sync (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .async_i({ser_data_i, ser_clk_i, ser_latch_i, therm_hot_i, over_cur_i}),
      .sync_o(pin_s)
   );
   spw_sync #(.W(4)) u_sync_bg (
      .ref_clk_i(ref_clk_i),
      .resetn_i(resetn_i),
      .async_i(below_gnd_i),
      .sync_o(bgnd_s)
   );
   assign {data_s, clk_s, latch_s, hot_s, over_cur_s} = pin_s;

   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         clk_prev_q <= 1'b0;
         latch_prev_q <= 1'b0;
      end
      else
      begin
         clk_prev_q <= clk_s;
         latch_prev_q <= latch_s;
      end
   end
   assign clk_rise = clk_s & ~clk_prev_q;
   assign latch_rise = latch_s & ~latch_prev_q;

   // First bit in ends up in D8, last in D0
   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         shift_q <= '0;
      else if (clk_rise)
         shift_q <= {shift_q[`SPW_WORD_W-2:0], data_s};
   end

   // Reset word has power_down_bit low: all outputs high impedance
   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         word_q <= '0;
      else if (latch_rise)
         word_q <= shift_q;
   end

   // Below-ground latch-off holds until reset stands in for a power cycle
   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         lock_q <= 1'b0;
      else if (|bgnd_s)
         lock_q <= 1'b1;
   end

   logic power_down_bit;
   assign power_down_bit = word_q[`SPW_PDOWN_POS];
   assign rail_en = power_down_bit & ~hot_s & ~lock_q & ~ctrl_q[0];

   spw_slot_sw_t a_sw, b_sw;
   spw_slot_decode u_dec_a (
      .enable_i(rail_en),
      .sup_code_i({word_q[`SPW_A_SUP_LSB+1], word_q[`SPW_A_SUP_LSB]}),
      .prg_code_i({word_q[`SPW_A_PROG_LSB], word_q[`SPW_A_PROG_LSB+1]}),
      .sw_o(a_sw)
   );
   spw_slot_decode u_dec_b (
      .enable_i(rail_en),
      .sup_code_i({word_q[`SPW_B_SUP_LSB], word_q[`SPW_B_SUP_LSB+1]}),
      .prg_code_i({word_q[`SPW_B_PROG_LSB], word_q[`SPW_B_PROG_LSB+1]}),
      .sw_o(b_sw)
   );

   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         slot_a_sw_o <= '0;
         slot_b_sw_o <= '0;
         quiescent_o <= 1'b1;
         limit_en_o <= 4'h0;
         fault_current_flag_n_o <= 1'b1;
      end
      else
      begin
         // Switches stay as selected; overcurrent engages the limiter, pulls the fault flag low and sets the overcurrent irq bit
         slot_a_sw_o <= a_sw;
         slot_b_sw_o <= b_sw;
         quiescent_o <= ~power_down_bit;
         limit_en_o <= over_cur_s;
         fault_current_flag_n_o <= ~(|over_cur_s);
      end
   end

   // Events: latch taken, overcurrent start, thermal trip, lock-off
   logic over_any_s;
   assign over_any_s = |over_cur_s;
   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         over_any_prev_q <= 1'b0;
         hot_prev_q <= 1'b0;
      end
      else
      begin
         over_any_prev_q <= over_any_s;
         hot_prev_q <= hot_s;
      end
   end
   assign irq_set = {(|bgnd_s) & ~lock_q, hot_s & ~hot_prev_q,
                     over_any_s & ~over_any_prev_q, latch_rise};

   // AXI4-Lite slave
   logic aw_q, w_q;
   logic [3:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic wr_go;
   assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
   assign s_axi_wready = ~w_q & ~s_axi_bvalid;
   assign wr_go = aw_q & w_q & ~s_axi_bvalid;
   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= 4'h0;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (wr_go)
         begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (awaddr_q == `SPW_OFF_CTRL || awaddr_q == `SPW_OFF_IRQ ||
                awaddr_q == `SPW_OFF_MASK)
               s_axi_bresp <= 2'h0;
            else
               s_axi_bresp <= 2'h2;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   logic wr_ok;
   assign wr_ok = wr_go & wstrb_q[0];
   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ctrl_q <= `SPW_CTRL_RST;
         mask_q <= `SPW_MASK_RST;
      end
      else if (wr_ok)
      begin
         if (awaddr_q == `SPW_OFF_CTRL)
            ctrl_q <= wdata_q[1:0];
         else if (awaddr_q == `SPW_OFF_MASK)
            mask_q <= wdata_q[3:0];
      end
   end

   // Set wins over a write-one clear in the same cycle
   logic [3:0] irq_clr;
   assign irq_clr = (wr_ok && awaddr_q == `SPW_OFF_IRQ) ? wdata_q[3:0] : 4'h0;
   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         irq_q <= 4'h0;
      else
         irq_q <= (irq_q & ~irq_clr) | irq_set;
   end
   assign irq_o = |(irq_q & mask_q);

   logic [31:0] rd_val;
   logic rd_bad;
   always_comb
   begin
      rd_val = 32'h0;
      rd_bad = 1'b0;
      if (s_axi_araddr == `SPW_OFF_CTRL)
         rd_val = {30'h0, ctrl_q};
      else if (s_axi_araddr == `SPW_OFF_STATUS)
         rd_val = {12'h0, lock_q, hot_s, over_cur_s, 5'h0, word_q};
      else if (s_axi_araddr == `SPW_OFF_IRQ)
         rd_val = {28'h0, irq_q};
      else if (s_axi_araddr == `SPW_OFF_MASK)
         rd_val = {28'h0, mask_q};
      else
         rd_bad = 1'b1;
   end
   assign s_axi_arready = ~s_axi_rvalid;
   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'h0;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= rd_bad ? 2'h2 : 2'h0;
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   a_shift_in: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      clk_rise |=> shift_q[0] == $past(data_s))
      else $error("serial bit not shifted in");
   a_latch_load: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      latch_rise |=> word_q == $past(shift_q))
      else $error("word not latched");
   a_word_hold: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      !latch_rise |=> $stable(word_q))
      else $error("word changed without latch");
   a_power_down_bit_hiz: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      !power_down_bit |=> slot_a_sw_o == '0 && slot_b_sw_o == '0 && quiescent_o)
      else $error("outputs driven in shutdown");
   a_over_flag: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      fault_current_flag_n_o == !$past(over_any_s))
      else $error("fault flag wrong");
   a_over_keep: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      over_any_s && rail_en && $past(rail_en) && $stable(word_q) |=>
      $stable(slot_a_sw_o) && $stable(slot_b_sw_o))
      else $error("overcurrent changed selection");
   a_limit_follow: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      limit_en_o == $past(over_cur_s))
      else $error("limiter not following overcurrent sense");
   a_quiet_off: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      power_down_bit |=> !quiescent_o)
      else $error("quiescent while powered");
   a_therm_off: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      hot_s |=> slot_a_sw_o == '0 && slot_b_sw_o == '0)
      else $error("outputs on during thermal limit");
   a_lock_off: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      lock_q |=> lock_q && slot_a_sw_o == '0 && slot_b_sw_o == '0)
      else $error("lock-off released");
   a_sup_gnd: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      rail_en && word_q[3:2] == 2'h0 |=> slot_a_sw_o.supply.gnd)
      else $error("slot a supply not grounded");
   a_slot_b_high: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      rail_en && word_q[7:6] == 2'h1 |=> slot_b_sw_o.supply.high_rail_sel)
      else $error("slot b high rail not selected");
   a_slot_a_low: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      rail_en && word_q[3:2] == 2'h1 |=> slot_a_sw_o.supply.low_rail_sel)
      else $error("slot a low rail not selected");
   a_prog_gnd_b: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
      rail_en && word_q[5:4] == 2'h0 |=> slot_b_sw_o.prog.gnd)
      else $error("slot b programming rail not grounded");
endmodule : spw_ctrl

/* File: bench/spw_link_model.sv */
// Purpose: Serial card controller model driving the three-line link
// Assumes: The block samples the link pins asynchronously
// Notes: Clock idles low between frames; data shows the inverse of its last bit
`timescale 1ns/10ps
module spw_link_model (
   output logic ser_data_o,
   output logic ser_clk_o,
   output logic ser_latch_o
);
   initial
   begin
      ser_data_o = 1'b0;
      ser_clk_o = 1'b0;
      ser_latch_o = 1'b0;
   end

   // First bit out ends up in D8
   task automatic shift_word(input logic [8:0] w);
      // Step off the ref_clk_i sampling edge
      #10;
      for (int i = 8; i >= 0; i--)
      begin
         ser_data_o = w[i];
         #100 ser_clk_o = 1'b1;
         #200 ser_clk_o = 1'b0;
         #100;
      end
      // Released line must not pass for a held bit
      ser_data_o = ~ser_data_o;
   endtask : shift_word

   task automatic latch_word();
      #10;
      #100 ser_latch_o = 1'b1;
      #200 ser_latch_o = 1'b0;
   endtask : latch_word
endmodule : spw_link_model

/* File: bench/spw_ctrl_bench.sv */
// Purpose: Self-checking bench for the card power switch control block
// Assumes: Interrupt mask bit high enables the matching status bit
// Notes: Link runs at 400 ns per bit, unrelated to ref_clk_i
`timescale 1ns/10ps
`include "spw_regs.svh"
module spw_ctrl_bench
   import spw_pkg::*;
;
   logic ref_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic ser_data_i, ser_clk_i, ser_latch_i;
   logic [3:0] over_cur_i = 4'h0;
   logic therm_hot_i = 1'b0;
   logic [3:0] below_gnd_i = 4'h0;
   spw_slot_sw_t slot_a_sw_o, slot_b_sw_o;
   logic [3:0] limit_en_o;
   logic quiescent_o, fault_current_flag_n_o, irq_o;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [8:0] cur;
   int errors = 0;
   int cmp_count = 0;
   int cycles = 0;

   always #25 ref_clk_i = ~ref_clk_i;

   spw_link_model link (.ser_data_o(ser_data_i), .ser_clk_o(ser_clk_i),
      .ser_latch_o(ser_latch_i));

   spw_ctrl dut (.ref_clk_i, .resetn_i, .ser_data_i, .ser_clk_i, .ser_latch_i, .over_cur_i,
      .therm_hot_i, .below_gnd_i, .slot_a_sw_o, .slot_b_sw_o, .limit_en_o, .quiescent_o,
      .fault_current_flag_n_o, .irq_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic finish_test();
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : finish_test

   // Whole run needs about 2000 cycles
   always @(posedge ref_clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         finish_test();
      end
   end

   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] st = 4'hF);
      logic aw_p, w_p;
      @(posedge ref_clk_i);
      aw_p = 1'b1;
      w_p = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge ref_clk_i);
         if (aw_p && s_axi_awready)
         begin
            aw_p = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w_p && s_axi_wready)
         begin
            w_p = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   task automatic rdr(input logic [3:0] a);
      @(posedge ref_clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge ref_clk_i);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rdr

   function automatic logic [5:0] exp_slot(input logic [8:0] w, input logic b);
      logic [1:0] sc, pc;
      sc = b ? {w[6], w[7]} : {w[3], w[2]};
      pc = b ? {w[4], w[5]} : {w[0], w[1]};
      if (!w[8])
         return 6'h00;
      return {(sc == 2'h1) ? 3'h2 : (sc == 2'h2) ? 3'h1 : 3'h4,
         (pc == 2'h0) ? 3'h4 : (pc == 2'h1) ? 3'h2 : (pc == 2'h2) ? 3'h1 : 3'h0};
   endfunction : exp_slot

   task automatic rails(input logic [8:0] w);
      check(32'(slot_a_sw_o), 32'(exp_slot(w, 1'b0)));
      check(32'(slot_b_sw_o), 32'(exp_slot(w, 1'b1)));
   endtask : rails

   // Latch plus sync and output stages take about four cycles
   task automatic commit(input logic [8:0] w);
      link.latch_word();
      repeat (8) @(posedge ref_clk_i);
      cur = w;
      rails(w);
      rdr(`SPW_OFF_STATUS);
      check(rd[8:0], w);
   endtask : commit

   task automatic send(input logic [8:0] w);
      link.shift_word(w);
      commit(w);
   endtask : send

   initial
   begin
      repeat (5) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      @(posedge ref_clk_i);
      rails(9'h000);
      check(fault_current_flag_n_o, 1'b1);
      check(irq_o, 1'b0);
      rdr(`SPW_OFF_MASK);
      check(rd, 32'h0);
      rdr(4'h2);
      check(rs, 2'h2);
      $display("test reset done");
      for (int c = 0; c < 16; c++)
         send({1'b1, 4'(c), ~4'(c)});
      check(quiescent_o, 1'b0);
      send(9'h108);
      send(9'h100);
      send(9'h104);
      link.shift_word(9'h0AA);
      rails(9'h104);
      commit(9'h0AA);
      check(quiescent_o, 1'b1);
      $display("test decode done");
      send(9'h1B6);
      wr(`SPW_OFF_IRQ, 32'hF);
      @(posedge ref_clk_i);
      over_cur_i <= 4'h4;
      repeat (5) @(posedge ref_clk_i);
      check(fault_current_flag_n_o, 1'b0);
      check(limit_en_o, 4'h4);
      rails(cur);
      check(irq_o, 1'b0);
      rdr(`SPW_OFF_STATUS);
      check(rd[17:14], 4'h4);
      rdr(`SPW_OFF_IRQ);
      check(rd[3:0], 4'h2);
      wr(`SPW_OFF_MASK, 32'h2);
      @(posedge ref_clk_i);
      check(irq_o, 1'b1);
      wr(`SPW_OFF_MASK, 32'h0, 4'h0);
      rdr(`SPW_OFF_MASK);
      check(rd, 32'h2);
      wr(`SPW_OFF_IRQ, 32'h2);
      @(posedge ref_clk_i);
      check(irq_o, 1'b0);
      over_cur_i <= 4'h0;
      repeat (5) @(posedge ref_clk_i);
      check(fault_current_flag_n_o, 1'b1);
      $display("test overcurrent done");
      wr(`SPW_OFF_CTRL, 32'h1);
      repeat (3) @(posedge ref_clk_i);
      rails(9'h000);
      wr(`SPW_OFF_CTRL, 32'h0);
      repeat (3) @(posedge ref_clk_i);
      rails(cur);
      therm_hot_i <= 1'b1;
      repeat (5) @(posedge ref_clk_i);
      rails(9'h000);
      rdr(`SPW_OFF_STATUS);
      check(rd[18], 1'b1);
      rdr(`SPW_OFF_IRQ);
      check(rd[3:0], 4'h4);
      therm_hot_i <= 1'b0;
      repeat (5) @(posedge ref_clk_i);
      rails(cur);
      $display("test thermal done");
      below_gnd_i <= 4'h2;
      repeat (5) @(posedge ref_clk_i);
      below_gnd_i <= 4'h0;
      repeat (5) @(posedge ref_clk_i);
      rails(9'h000);
      rdr(`SPW_OFF_STATUS);
      check(rd[19], 1'b1);
      rdr(`SPW_OFF_IRQ);
      check(rd[3:0], 4'hC);
      resetn_i <= 1'b0;
      repeat (5) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      @(posedge ref_clk_i);
      send(9'h1B6);
      $display("test lock done");
      finish_test();
   end
endmodule : spw_ctrl_bench
